// ==== hdl/ldr_regs.sv ====
// Purpose: configuration, status and fault registers of the LED driver
// Assumes: byte-wide register port from the serial front end, one clock
// Notes: fault inputs are raw analog comparator levels, synchronised here
`timescale 1ns/1ps
`include "ldr_consts.svh"
module ldr_regs #(
	parameter int unsigned MS_CYCLES = `LDR_MS_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output ldr_pkg::ldr_byte_t rdata,
	input wire logic [7:0] nvm_config,
	input wire logic nvm_valid,
	input wire logic external_current_select,
	input wire logic brightness_change,
	input wire logic thermistor_absent,
	input wire logic ext_sensor_low_limit,
	input wire logic ext_sensor_high_limit,
	input wire logic input_overvoltage,
	input wire logic input_undervoltage,
	input wire logic thermal_shutdown,
	input wire logic boost_overcurrent,
	input wire logic boost_overvoltage,
	input wire logic input_switch_overcurrent,
	input wire logic pump_undervoltage,
	input wire logic [3:0] string_open,
	input wire logic [3:0] string_short,
	input wire logic [10:0] die_temp,
	output logic [7:0] max_current_ma,
	output logic advanced_slope,
	output logic [9:0] slope_ms,
	output logic transition_complete
);
	import ldr_pkg::*;

	// nineteen pin levels: three sensor flags, seven faults, eight string
	// levels and the brightness change request at the top
	localparam int NSYNC = 19;

	typedef struct packed {
		logic [NSYNC-1:0] s1;
		logic [NSYNC-1:0] s2;
		logic cfg_loaded;
		ldr_byte_t cfg;
		logic [6:0] fault;
		logic open_f;
		logic short_f;
		logic [3:0] which;
		ldr_temp_t temp_latch;
		ldr_slope_e slope_st;
		logic [9:0] slope_cnt;
		ldr_byte_t rdata;
	} ldr_regs_s;

	ldr_regs_s st;
	ldr_regs_s next_st;
	logic ms_tick;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sy;
	logic clear_cmd;
	logic temp_hi_read;

	// decode of the slope code into milliseconds, also used for the output
	function automatic logic [9:0] slope_to_ms(input logic [2:0] code);
		case (code)
			3'h0: slope_to_ms = 10'd0;
			3'h1: slope_to_ms = 10'd1;
			3'h2: slope_to_ms = 10'd2;
			3'h3: slope_to_ms = 10'd52;
			3'h4: slope_to_ms = 10'd105;
			3'h5: slope_to_ms = 10'd210;
			3'h6: slope_to_ms = 10'd315;
			default: slope_to_ms = 10'd511;
		endcase
	endfunction : slope_to_ms

	// decode of the scale code into the string current ceiling
	function automatic logic [7:0] scale_to_ma(input logic [2:0] code);
		case (code)
			3'h0: scale_to_ma = 8'd25;
			3'h1: scale_to_ma = 8'd30;
			3'h2: scale_to_ma = 8'd50;
			3'h3: scale_to_ma = 8'd60;
			3'h4: scale_to_ma = 8'd80;
			3'h5: scale_to_ma = 8'd100;
			3'h6: scale_to_ma = 8'd120;
			default: scale_to_ma = 8'd150;
		endcase
	endfunction : scale_to_ma

	ldr_ms_tick #(
		.CYCLES(MS_CYCLES)
	) u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.restart(sy[18]),
		.tick(ms_tick)
	);

	// all pin levels pass two flops; only the second stage is read
	assign raw_in = {brightness_change, string_short, string_open,
		pump_undervoltage, input_switch_overcurrent, boost_overvoltage,
		boost_overcurrent, thermal_shutdown, input_undervoltage,
		input_overvoltage, ext_sensor_high_limit, ext_sensor_low_limit,
		thermistor_absent};
	assign sy = st.s2;

	assign clear_cmd = wr_en && addr == `LDR_ADDR_CLEAR
		&& wdata[`LDR_CLEAR_BIT];
	assign temp_hi_read = rd_en && addr == `LDR_ADDR_TEMP_HI;

	always_comb begin
		next_st = st;
		next_st.s1 = raw_in;
		next_st.s2 = st.s1;
		// nvm copy wins once; later host writes override it
		if (!st.cfg_loaded && nvm_valid) begin
			next_st.cfg = {1'b0, nvm_config[6:0]};
			next_st.cfg_loaded = 1'b1;
		end else if (wr_en && addr == `LDR_ADDR_CONFIG) begin
			next_st.cfg = wdata & `LDR_CFG_WMASK;
		end
		// clear first, then new events, so a same-cycle event survives
		if (clear_cmd) begin
			next_st.fault = '0;
			next_st.open_f = 1'b0;
			next_st.short_f = 1'b0;
			next_st.which = '0;
		end
		// bits 6..0: ovp, uvlo, tsd, boost_overcurrent, boost_overvoltage, switch, pump
		next_st.fault = next_st.fault | {sy[3], sy[4], sy[5], sy[6],
			sy[7], sy[8], sy[9]};
		next_st.open_f = next_st.open_f | (|sy[13:10]);
		next_st.short_f = next_st.short_f | (|sy[17:14]);
		next_st.which = next_st.which | sy[13:10] | sy[17:14];
		// reading the upper byte freezes a coherent sample for the lower
		if (temp_hi_read) begin
			next_st.temp_latch = die_temp;
		end
		// slope timer: restart on a brightness change, count ms ticks
		case (st.slope_st)
			LDR_IDLE: begin
				next_st.slope_st = LDR_DONE;
			end
			LDR_RUN: begin
				if (st.slope_cnt == 10'd0) begin
					next_st.slope_st = LDR_DONE;
				end else if (ms_tick) begin
					next_st.slope_cnt = st.slope_cnt - 10'd1;
				end
			end
			LDR_DONE: begin
				next_st.slope_st = LDR_DONE;
			end
			default: begin
				next_st.slope_st = LDR_DONE;
			end
		endcase
		if (sy[18]) begin
			next_st.slope_st = LDR_RUN;
			next_st.slope_cnt = slope_to_ms(st.cfg[2:0]);
		end
		// read data mux, registered
		next_st.rdata = 8'h00;
		if (rd_en) begin
			case (addr)
				`LDR_ADDR_CONFIG: next_st.rdata = st.cfg;
				`LDR_ADDR_STATUS: next_st.rdata = {4'h0,
					st.slope_st == LDR_DONE, sy[0], sy[1], sy[2]};
				`LDR_ADDR_FAULT: next_st.rdata = {1'b0, st.fault};
				`LDR_ADDR_STRING: next_st.rdata = {2'h0, st.open_f,
					st.short_f, st.which};
				`LDR_ADDR_REV: next_st.rdata = {`LDR_FULL_REV,
					`LDR_MASK_REV};
				`LDR_ADDR_TEMP_HI: next_st.rdata = {5'h0,
					die_temp[10:8]};
				`LDR_ADDR_TEMP_LO: next_st.rdata = st.temp_latch[7:0];
				default: next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
			st.slope_st <= LDR_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	// external control leaves the ceiling to the pin; report full scale
	assign max_current_ma = external_current_select ? 8'd150
		: scale_to_ma(st.cfg[6:4]);
	assign advanced_slope = st.cfg[`LDR_CFG_ADV_BIT];
	assign slope_ms = slope_to_ms(st.cfg[2:0]);
	assign transition_complete = st.slope_st == LDR_DONE;

	a_clear_faults: assert property (@(posedge clk) disable iff (!rst_n)
		clear_cmd && sy[9:3] == 7'h0 |=> st.fault == 7'h0)
		else $error("fault clear ignored");
	a_fault_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		!clear_cmd && $past(!clear_cmd) |-> (st.fault & $past(st.fault))
		== $past(st.fault)) else $error("fault flag dropped");
	a_ovp_sets: assert property (@(posedge clk) disable iff (!rst_n)
		sy[3] |=> st.fault[6]) else $error("ovp not flagged");
	a_open_sets: assert property (@(posedge clk) disable iff (!rst_n)
		sy[10] |=> st.open_f && st.which[0])
		else $error("open string not flagged");
	a_short_sets: assert property (@(posedge clk) disable iff (!rst_n)
		sy[17] |=> st.short_f && st.which[3])
		else $error("short string not flagged");
	a_temp_latch: assert property (@(posedge clk) disable iff (!rst_n)
		temp_hi_read ##1 (rd_en && addr == `LDR_ADDR_TEMP_LO) |=>
		rdata == $past(die_temp[7:0], 2))
		else $error("temp low byte mismatch");
	a_slope_busy: assert property (@(posedge clk) disable iff (!rst_n)
		sy[18] |=> !transition_complete)
		else $error("slope not busy");
	a_rev_read: assert property (@(posedge clk) disable iff (!rst_n)
		rd_en && addr == `LDR_ADDR_REV |=> rdata == {`LDR_FULL_REV,
		`LDR_MASK_REV}) else $error("revision wrong");
	a_cfg_write: assert property (@(posedge clk) disable iff (!rst_n)
		wr_en && addr == `LDR_ADDR_CONFIG && st.cfg_loaded |=>
		st.cfg == ($past(wdata) & 8'h7f)) else $error("cfg write lost");
endmodule : ldr_regs

// ==== include/ldr_consts.svh ====
// Purpose: offsets, field positions, revision values and timing counts
// Assumes: 25 MHz clock, 8-bit register port with 8-bit addresses
// Notes: included by the design modules and the bench
//
// Overview of operation
// - current scale field 6:4 picks 25..150 mA unless external control
// - bit 3 selects linear slope (0) or advanced smooth slope (1)
// - slope field 2:0 picks 0,1,2,52,105,210,315,511 ms transition time
// - status bit 3 reads 0 while sloping, 1 once transition is done
// - status bit 2 reads 1 when the thermistor is absent
// - status bit 1 reads 1 when the external sensor low limit is hit
// - status bit 0 reads 1 when the external sensor high limit is hit
// - fault bit 6 flags input overvoltage
// - fault bit 5 flags input undervoltage lockout
// - fault bit 4 flags thermal shutdown
// - fault bit 3 flags boost overcurrent
// - fault bit 2 flags boost output overvoltage
// - fault bit 1 flags input switch overcurrent
// - fault bit 0 flags charge pump output too low
// - string fault bit 5 flags an open string on any output
// - string fault bit 4 flags a shorted string on any output
// - string fault bits 3:0 mark the faulty output, one bit each
// - writing 1 to fault clear bit 0 clears the fault flags
// - revision register: full-layer rev high nibble, mask rev low nibble
// - upper temp read returns bits 10:8 and latches all eleven bits
// - configuration reset content comes from nonvolatile memory
`ifndef LDR_CONSTS_SVH
`define LDR_CONSTS_SVH

`define LDR_ADDR_CONFIG 8'h0d
`define LDR_ADDR_STATUS 8'h0e
`define LDR_ADDR_FAULT 8'h0f
`define LDR_ADDR_STRING 8'h10
`define LDR_ADDR_CLEAR 8'h11
`define LDR_ADDR_REV 8'h12
`define LDR_ADDR_TEMP_HI 8'h13
`define LDR_ADDR_TEMP_LO 8'h14

`define LDR_CFG_SCALE_HI 6
`define LDR_CFG_SCALE_LO 4
`define LDR_CFG_ADV_BIT 3
`define LDR_CFG_SLOPE_HI 2
`define LDR_CFG_SLOPE_LO 0
`define LDR_CFG_WMASK 8'h7f
`define LDR_CLEAR_BIT 0
`define LDR_STRING_OPEN_BIT 5
`define LDR_STRING_SHORT_BIT 4

// arbitrary neutral revision values
`define LDR_FULL_REV 4'h1
`define LDR_MASK_REV 4'h0

// one millisecond at 25 MHz
`define LDR_CLK_HZ 25000000
`define LDR_MS_CYCLES (`LDR_CLK_HZ / 1000)

`endif

// ==== include/ldr_pkg.sv ====
// Purpose: types shared by the register bank
// Assumes: constants come from ldr_consts.svh
// Notes: holds types only
package ldr_pkg;
	typedef logic [7:0] ldr_byte_t;
	typedef logic [10:0] ldr_temp_t;
	typedef enum logic [2:0] {
		LDR_IDLE = 3'b001,
		LDR_RUN = 3'b010,
		LDR_DONE = 3'b100
	} ldr_slope_e;
endpackage : ldr_pkg

// ==== hdl/ldr_ms_tick.sv ====
// Purpose: one-cycle millisecond enable from the system clock
// Assumes: synchronous active-low reset
// Notes: paces the slope timer
`timescale 1ns/1ps
`include "ldr_consts.svh"
module ldr_ms_tick #(
	parameter int unsigned CYCLES = `LDR_MS_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic restart,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} ldr_tick_s;
	ldr_tick_s st;
	ldr_tick_s next_st;

	// restart realigns the tick so a new transition gets whole milliseconds
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (restart || st.cnt >= CYCLES - 1) begin
			next_st.cnt = '0;
			next_st.tick = !restart;
		end else begin
			next_st.cnt = st.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
endmodule : ldr_ms_tick

// ==== verification/ldr_host.sv ====
// Purpose: host controller model on the byte-wide register port
// Assumes: strobes change on the falling edge, one access at a time
// Notes: address is scrambled once a strobe drops, write data once a write strobe drops
`timescale 1ns/1ps
module ldr_host (
	input wire logic clk,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	// idle port at time zero
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end

	// one write, held across exactly one rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		addr = ~a; // stale qualifiers must not look valid
		wdata = ~d;
	endtask : wr

	// one read; the answer stands in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		addr = ~a;
		d = rdata;
	endtask : rd

	// high byte first so both halves come from one latched sample;
	// the two reads sit on consecutive edges, strobe held between them
	task automatic rd_temp(output logic [7:0] hi, output logic [7:0] lo);
		@(negedge clk);
		addr = 8'h13;
		rd_en = 1'b1;
		@(negedge clk);
		hi = rdata;
		addr = 8'h14;
		@(negedge clk);
		rd_en = 1'b0;
		addr = 8'heb;
		lo = rdata;
	endtask : rd_temp
endmodule : ldr_host

// ==== verification/tb_ldr_regs.sv ====
// Purpose: self-checking bench for the register bank
// Assumes: slope millisecond shortened to 10 cycles
// Notes: all register traffic goes through the host model
`timescale 1ns/1ps
`include "ldr_consts.svh"
module tb_ldr_regs;
	import ldr_pkg::*;
	localparam logic [7:0] MA [8] = '{25, 30, 50, 60, 80, 100, 120, 150};
	localparam logic [9:0] MS [8] = '{0, 1, 2, 52, 105, 210, 315, 511};
	logic clk, rst_n, wr_en, rd_en, nvm_valid, ext_sel, bchg, adv, done;
	logic therm, lo_lim, hi_lim;
	logic [7:0] addr, wdata, nvm_config, cur_ma, d, w, hi, lo;
	ldr_byte_t rdata;
	logic [6:0] flt; // bit i drives fault register bit i
	logic [3:0] s_open, s_short;
	logic [10:0] die_temp, t;
	logic [9:0] sl_ms;
	logic [31:0] lfsr = 32'h7579612c;
	int bad_count = 0;
	int cmp_count = 0;

	ldr_regs #(.MS_CYCLES(10)) dut (.clk(clk), .rst_n(rst_n),
		.wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
		.rdata(rdata), .nvm_config(nvm_config), .nvm_valid(nvm_valid),
		.external_current_select(ext_sel), .brightness_change(bchg),
		.thermistor_absent(therm), .ext_sensor_low_limit(lo_lim),
		.ext_sensor_high_limit(hi_lim), .input_overvoltage(flt[6]),
		.input_undervoltage(flt[5]), .thermal_shutdown(flt[4]),
		.boost_overcurrent(flt[3]), .boost_overvoltage(flt[2]),
		.input_switch_overcurrent(flt[1]), .pump_undervoltage(flt[0]),
		.string_open(s_open), .string_short(s_short), .die_temp(die_temp),
		.max_current_ma(cur_ma), .advanced_slope(adv), .slope_ms(sl_ms),
		.transition_complete(done));
	ldr_host host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .rdata(rdata));

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd

	// external control pins the ceiling at the top code
	function automatic logic [7:0] exp_ma(input logic [2:0] c, input logic e);
		return e ? MA[7] : MA[c];
	endfunction : exp_ma

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic finish_test();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// a hang is cut at about seventeen times the expected run length
	initial begin
		#200000;
		bad_count++;
		finish_test();
	end

	initial begin
		{rst_n, nvm_valid, ext_sel, bchg, therm, lo_lim, hi_lim} = 7'h00;
		{flt, s_open, s_short, die_temp} = '0;
		nvm_config = 8'(rnd()) | 8'h80;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		nvm_valid = 1'b1;
		host.rd(`LDR_ADDR_CONFIG, d);
		chk("cfg_nvm", d, nvm_config & 8'h7f);
		// every scale and slope code, random bit 7 must read back 0
		for (int c = 0; c < 8; c++) begin
			w = 8'(rnd());
			w[6:4] = 3'(c);
			w[2:0] = 3'(7 - c);
			ext_sel = (c == 5);
			host.wr(`LDR_ADDR_CONFIG, w);
			host.rd(`LDR_ADDR_CONFIG, d);
			chk("cfg", d, w & 8'h7f);
			chk("max_ma", cur_ma, exp_ma(3'(c), ext_sel));
			chk("adv", adv, w[3]);
			chk("slope", sl_ms, MS[7 - c]);
		end
		// one-millisecond slope, live sensor flags read beside it
		{therm, lo_lim, hi_lim} = 3'(rnd());
		host.wr(`LDR_ADDR_CONFIG, 8'h01);
		bchg = 1'b1;
		@(negedge clk);
		bchg = 1'b0;
		repeat (4) @(negedge clk);
		host.rd(`LDR_ADDR_STATUS, d);
		chk("sloping", d, {5'h0, therm, lo_lim, hi_lim});
		chk("busy", done, 1'b0);
		repeat (40) @(negedge clk);
		host.rd(`LDR_ADDR_STATUS, d);
		chk("slope_end", d, {5'h1, therm, lo_lim, hi_lim});
		chk("done", done, 1'b1);
		// flip every sensor flag so each bit is seen both ways
		{therm, lo_lim, hi_lim} = ~{therm, lo_lim, hi_lim};
		repeat (3) @(negedge clk);
		host.rd(`LDR_ADDR_STATUS, d);
		chk("flags_inv", d, {5'h1, therm, lo_lim, hi_lim});
		// each supply fault as a short pulse: sticky until cleared
		for (int i = 0; i < 7; i++) begin
			flt = 7'(1 << i);
			repeat (2) @(negedge clk);
			flt = '0;
			repeat (4) @(negedge clk);
			host.rd(`LDR_ADDR_FAULT, d);
			chk("fault", d, 8'(1 << i));
			host.wr(`LDR_ADDR_CLEAR, 8'(rnd()) | 8'h01);
			host.rd(`LDR_ADDR_FAULT, d);
			chk("fault_clr", d, 8'h00);
		end
		// open then short on each output; a write with bit 0 low keeps it
		for (int k = 0; k < 8; k++) begin
			s_open = (k < 4) ? 4'(1 << k) : 4'h0;
			s_short = (k < 4) ? 4'h0 : 4'(1 << (k - 4));
			repeat (2) @(negedge clk);
			{s_open, s_short} = 8'h00;
			host.wr(`LDR_ADDR_CLEAR, 8'(rnd()) & 8'hfe);
			host.rd(`LDR_ADDR_STRING, d);
			chk("string", d, {2'b00, k < 4, k > 3, 4'(1 << k[1:0])});
			host.wr(`LDR_ADDR_CLEAR, 8'h01);
			host.rd(`LDR_ADDR_STRING, d);
			chk("string_clr", d, 8'h00);
		end
		host.wr(`LDR_ADDR_REV, 8'hff);
		host.rd(`LDR_ADDR_REV, d);
		chk("rev", d, {`LDR_FULL_REV, `LDR_MASK_REV});
		// mid-run reset: a held fault drops, config reloads from nvm
		flt = 7'h01;
		repeat (4) @(negedge clk);
		flt = '0;
		host.rd(`LDR_ADDR_FAULT, d);
		chk("fault_pre", d, 8'h01);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		host.rd(`LDR_ADDR_FAULT, d);
		chk("fault_rst", d, 8'h00);
		host.rd(`LDR_ADDR_CONFIG, d);
		chk("cfg_reset", d, nvm_config & 8'h7f);
		chk("done_rst", done, 1'b1);
		// temperature moves between the two reads; low byte stays latched
		for (int j = 0; j < 4; j++) begin
			t = 11'(rnd());
			die_temp = t;
			fork
				host.rd_temp(hi, lo);
				begin
					repeat (2) @(negedge clk);
					die_temp = ~t;
				end
			join
			chk("temp_hi", hi, {5'h00, t[10:8]});
			chk("temp_lo", lo, t[7:0]);
		end
		host.wr(8'h20, 8'hff);
		host.rd(8'h20, d);
		chk("unmapped", d, 8'h00);
		@(negedge clk);
		chk("rdata_idle", rdata, 8'h00);
		finish_test();
	end
endmodule : tb_ldr_regs
